// [hdl/dual_uart_pin_control.sv]
// two-channel serial pin control with an apb register slave
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
// Notes on behaviour
// - a completed write stores the data byte in the addressed writable channel register
// - modem control bit 3 drives the interrupt pin and pulls user output low
// - user output of each channel is high after reset
// - reset returns every register and output to its reset value
// - during reset the transmit pin idles high and the receive path is blocked
// - rising ring input edge raises a maskable modem interrupt; level is readable
// - modem control bit 1 drives request-to-send low, clearing it drives high
// - request-to-send is high after reset
// - receive halt affects request-to-send only with automatic request enabled
// - loopback ignores the receive pin and feeds transmit data to the receiver
// - receive-ready goes low at trigger level or on receive timeout
// - receive-ready returns high when receive fifo empty or holds an error
// - transmit-ready goes low when free space reaches the transmit trigger
// - transmit-ready goes high when the transmit buffer is full
// - a read returns the addressed channel register on the data bus
// - modem control bit 0 drives data-terminal-ready low, clear or reset high
module dual_uart_pin_control
#(
    parameter int FIFO_DEPTH = uart_pin_pkg::FIFO_DEPTH,
    parameter int LEVEL_W = $clog2(FIFO_DEPTH + 1)
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [uart_pin_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ring_a_n,
    input wire logic ring_b_n,
    input wire logic rxd_a,
    input wire logic rxd_b,
    output logic txd_a,
    output logic txd_b,
    output logic rts_a_n,
    output logic rts_b_n,
    output logic dtr_a_n,
    output logic dtr_b_n,
    output logic user_output_a_n,
    output logic user_output_b_n,
    output logic channel_irq_a,
    output logic channel_irq_b,
    output logic channel_irq_a_oe_n,
    output logic channel_irq_b_oe_n,
    output logic rx_ready_a_n,
    output logic rx_ready_b_n,
    output logic tx_ready_a_n,
    output logic tx_ready_b_n,
    input wire logic core_txd_a,
    input wire logic core_txd_b,
    output logic core_rxd_a,
    output logic core_rxd_b,
    input wire logic [LEVEL_W-1:0] rx_level_a,
    input wire logic [LEVEL_W-1:0] rx_level_b,
    input wire logic rx_timeout_a,
    input wire logic rx_timeout_b,
    input wire logic rx_error_a,
    input wire logic rx_error_b,
    input wire logic [LEVEL_W-1:0] tx_free_a,
    input wire logic [LEVEL_W-1:0] tx_free_b,
    input wire logic rx_halt_a,
    input wire logic rx_halt_b
);
    import uart_pin_pkg::*;

    localparam int MAX_TRIG = ((1 << TRIG_FIELD_W) - 1) * TRIG_UNIT;

    // refuse at elaboration: thresholds above the depth, or a level too wide for one read byte
    if (FIFO_DEPTH < MAX_TRIG || LEVEL_W < $clog2(FIFO_DEPTH + 1) || LEVEL_W > DATA_W)
    begin : g_bad_params
        $error("dual_uart_pin_control: fifo depth or level width unsupported");
    end

    logic [DATA_W-1:0] modem_control_reg [2];
    logic [DATA_W-1:0] enhanced_feature_reg [2];
    logic [DATA_W-1:0] irq_enable_reg [2];
    logic [DATA_W-1:0] trigger_level_reg [2];
    logic [DATA_W-1:0] scratch_reg [2];
    logic [DATA_W-1:0] modem_status_reg [2];
    logic [DATA_W-1:0] pin_status [2];
    logic [LEVEL_W-1:0] rx_threshold [2];
    logic [LEVEL_W-1:0] tx_threshold [2];
    logic [LEVEL_W-1:0] rx_level [2];
    logic [LEVEL_W-1:0] tx_free [2];
    logic status_read [2];

    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic access;
    logic done;
    logic addr_ok;
    logic chan;
    logic [2:0] idx;
    logic [DATA_W-1:0] rd_byte;

    assign rx_level[0] = rx_level_a;
    assign rx_level[1] = rx_level_b;
    assign tx_free[0] = tx_free_a;
    assign tx_free[1] = tx_free_b;

    // decode: bits 4..2 pick the register, bit 5 the channel
    assign chan = paddr[CHAN_SEL_BIT];
    assign idx = paddr[4:2];
    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[APB_AW-1:CHAN_SEL_BIT+1] == '0);
    assign access = psel & penable;
    assign done = access & pready_reg;

    // one wait state so read data leaves a flip-flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end
        else
        begin
            pready_reg <= access & ~pready_reg;
            pslverr_reg <= access & ~pready_reg & ~addr_ok;
            if (access && !pready_reg && !pwrite)
                prdata_reg <= addr_ok ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign prdata = prdata_reg;

    // read mux for the addressed channel only
    always_comb
    begin
        rd_byte = '0;
        unique case (idx)
            IDX_SCRATCH: rd_byte = scratch_reg[chan];
            IDX_IRQ_ENABLE: rd_byte = irq_enable_reg[chan];
            IDX_ENHANCED: rd_byte = enhanced_feature_reg[chan];
            IDX_TRIGGER: rd_byte = trigger_level_reg[chan];
            IDX_MODEM_CTRL: rd_byte = modem_control_reg[chan];
            IDX_PIN_STATUS: rd_byte = pin_status[chan];
            IDX_MODEM_STATUS: rd_byte = modem_status_reg[chan];
            IDX_LEVELS: rd_byte = DATA_W'(rx_level[chan]);
        endcase
    end

    for (genvar c = 0; c < 2; c++)
    begin : g_regs
        logic hit;
        logic [TRIG_FIELD_W-1:0] rx_field;
        logic [TRIG_FIELD_W-1:0] tx_field;

        assign hit = done & addr_ok & (chan == 1'(c));
        assign status_read[c] = hit & ~pwrite & (idx == IDX_MODEM_STATUS);
        assign rx_field = trigger_level_reg[c][TRIG_RX_LSB +: TRIG_FIELD_W];
        assign tx_field = trigger_level_reg[c][TRIG_TX_LSB +: TRIG_FIELD_W];
        assign rx_threshold[c] = (rx_field == '0) ? LEVEL_W'(1) : LEVEL_W'(rx_field * TRIG_UNIT);
        assign tx_threshold[c] = (tx_field == '0) ? LEVEL_W'(1) : LEVEL_W'(tx_field * TRIG_UNIT);

        // writes land at the edge where the access completes
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                modem_control_reg[c] <= MCR_RESET;
                enhanced_feature_reg[c] <= EFR_RESET;
                irq_enable_reg[c] <= IER_RESET;
                trigger_level_reg[c] <= TRIG_RESET;
                scratch_reg[c] <= SCRATCH_RESET;
            end
            else if (hit && pwrite)
            begin
                unique case (idx)
                    IDX_SCRATCH: scratch_reg[c] <= pwdata[DATA_W-1:0];
                    IDX_IRQ_ENABLE: irq_enable_reg[c] <= pwdata[DATA_W-1:0];
                    IDX_ENHANCED: enhanced_feature_reg[c] <= pwdata[DATA_W-1:0];
                    IDX_TRIGGER: trigger_level_reg[c] <= pwdata[DATA_W-1:0];
                    IDX_MODEM_CTRL: modem_control_reg[c] <= pwdata[DATA_W-1:0];
                    IDX_PIN_STATUS,
                    IDX_MODEM_STATUS,
                    IDX_LEVELS:
                    begin
                    end
                endcase
            end
        end
    end

    // two identical channels
    uart_channel_pins #(
        .LEVEL_W(LEVEL_W)
    ) u_chan_a (
        .pclk(pclk),
        .presetn(presetn),
        .modem_control_reg(modem_control_reg[0]),
        .enhanced_feature_reg(enhanced_feature_reg[0]),
        .irq_enable_reg(irq_enable_reg[0]),
        .rx_threshold(rx_threshold[0]),
        .tx_threshold(tx_threshold[0]),
        .status_read(status_read[0]),
        .modem_status(modem_status_reg[0]),
        .pin_status(pin_status[0]),
        .ring_n(ring_a_n),
        .rxd(rxd_a),
        .txd(txd_a),
        .rts_n(rts_a_n),
        .dtr_n(dtr_a_n),
        .user_output_n(user_output_a_n),
        .channel_irq(channel_irq_a),
        .channel_irq_oe_n(channel_irq_a_oe_n),
        .rx_ready_n(rx_ready_a_n),
        .tx_ready_n(tx_ready_a_n),
        .core_txd(core_txd_a),
        .core_rxd(core_rxd_a),
        .rx_level(rx_level_a),
        .rx_timeout(rx_timeout_a),
        .rx_error(rx_error_a),
        .tx_free(tx_free_a),
        .rx_halt(rx_halt_a)
    );

    uart_channel_pins #(
        .LEVEL_W(LEVEL_W)
    ) u_chan_b (
        .pclk(pclk),
        .presetn(presetn),
        .modem_control_reg(modem_control_reg[1]),
        .enhanced_feature_reg(enhanced_feature_reg[1]),
        .irq_enable_reg(irq_enable_reg[1]),
        .rx_threshold(rx_threshold[1]),
        .tx_threshold(tx_threshold[1]),
        .status_read(status_read[1]),
        .modem_status(modem_status_reg[1]),
        .pin_status(pin_status[1]),
        .ring_n(ring_b_n),
        .rxd(rxd_b),
        .txd(txd_b),
        .rts_n(rts_b_n),
        .dtr_n(dtr_b_n),
        .user_output_n(user_output_b_n),
        .channel_irq(channel_irq_b),
        .channel_irq_oe_n(channel_irq_b_oe_n),
        .rx_ready_n(rx_ready_b_n),
        .tx_ready_n(tx_ready_b_n),
        .core_txd(core_txd_b),
        .core_rxd(core_rxd_b),
        .rx_level(rx_level_b),
        .rx_timeout(rx_timeout_b),
        .rx_error(rx_error_b),
        .tx_free(tx_free_b),
        .rx_halt(rx_halt_b)
    );
endmodule

// [hdl/uart_pin_pkg.sv]
// constants for the dual serial channel pin control block
package uart_pin_pkg;
    localparam int DATA_W = 8;
    localparam int APB_AW = 8;
    localparam int FIFO_DEPTH = 64;
    // register indexes inside one channel; byte address is four times the index
    localparam logic [2:0] IDX_SCRATCH = 3'h0;
    localparam logic [2:0] IDX_IRQ_ENABLE = 3'h1;
    localparam logic [2:0] IDX_ENHANCED = 3'h2;
    localparam logic [2:0] IDX_TRIGGER = 3'h3;
    localparam logic [2:0] IDX_MODEM_CTRL = 3'h4;
    localparam logic [2:0] IDX_PIN_STATUS = 3'h5;
    localparam logic [2:0] IDX_MODEM_STATUS = 3'h6;
    localparam logic [2:0] IDX_LEVELS = 3'h7;
    // address bit that picks channel b
    localparam int CHAN_SEL_BIT = 5;
    // modem control bits
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_IRQ_DRIVE = 3;
    localparam int MCR_LOOPBACK = 4;
    // enhanced feature bit
    localparam int EFR_AUTO_RTS = 6;
    // interrupt enable bit for modem status
    localparam int IER_MODEM = 3;
    // modem status bits
    localparam int MSR_RING_EDGE = 2;
    localparam int MSR_RING_LEVEL = 6;
    // trigger register fields, in units of four entries, zero meaning one entry
    localparam int TRIG_RX_LSB = 0;
    localparam int TRIG_TX_LSB = 4;
    localparam int TRIG_FIELD_W = 4;
    localparam int TRIG_UNIT = 4;
    // pin status bits
    localparam int PST_RX_READY_N = 0;
    localparam int PST_TX_READY_N = 1;
    localparam int PST_IRQ = 2;
    localparam int PST_RTS_N = 3;
    // reset values
    localparam logic [DATA_W-1:0] MCR_RESET = 8'h00;
    localparam logic [DATA_W-1:0] EFR_RESET = 8'h00;
    localparam logic [DATA_W-1:0] IER_RESET = 8'h00;
    localparam logic [DATA_W-1:0] TRIG_RESET = 8'h00;
    localparam logic [DATA_W-1:0] SCRATCH_RESET = 8'h00;
endpackage

// [hdl/uart_channel_pins.sv]
// pin logic of one serial channel: handshake pins, ring event, loopback, ready outputs
`timescale 1ns/1ns
module uart_channel_pins
#(
    parameter int LEVEL_W = 7
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [uart_pin_pkg::DATA_W-1:0] modem_control_reg,
    input wire logic [uart_pin_pkg::DATA_W-1:0] enhanced_feature_reg,
    input wire logic [uart_pin_pkg::DATA_W-1:0] irq_enable_reg,
    input wire logic [LEVEL_W-1:0] rx_threshold,
    input wire logic [LEVEL_W-1:0] tx_threshold,
    input wire logic status_read,
    output logic [uart_pin_pkg::DATA_W-1:0] modem_status,
    output logic [uart_pin_pkg::DATA_W-1:0] pin_status,
    input wire logic ring_n,
    input wire logic rxd,
    output logic txd,
    output logic rts_n,
    output logic dtr_n,
    output logic user_output_n,
    output logic channel_irq,
    output logic channel_irq_oe_n,
    output logic rx_ready_n,
    output logic tx_ready_n,
    input wire logic core_txd,
    output logic core_rxd,
    input wire logic [LEVEL_W-1:0] rx_level,
    input wire logic rx_timeout,
    input wire logic rx_error,
    input wire logic [LEVEL_W-1:0] tx_free,
    input wire logic rx_halt
);
    import uart_pin_pkg::*;

    logic ring_prev_reg;
    logic ring_edge_reg;
    logic loopback;
    logic rts_active;

    assign loopback = modem_control_reg[MCR_LOOPBACK];
    // auto flow control gates the request only when enabled
    assign rts_active = modem_control_reg[MCR_RTS] & ~(enhanced_feature_reg[EFR_AUTO_RTS] & rx_halt);

    // ring input edge, sticky until a status read; a new edge beats the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ring_prev_reg <= 1'b1;
            ring_edge_reg <= 1'b0;
        end
        else
        begin
            ring_prev_reg <= ring_n;
            if (ring_n && !ring_prev_reg)
                ring_edge_reg <= 1'b1;
            else if (status_read)
                ring_edge_reg <= 1'b0;
        end
    end

    // serial path: tx pin idles high in reset and in loopback
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            txd <= 1'b1;
            core_rxd <= 1'b1;
        end
        else
        begin
            txd <= loopback ? 1'b1 : core_txd;
            core_rxd <= loopback ? core_txd : rxd;
        end
    end

    // modem control outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rts_n <= 1'b1;
            dtr_n <= 1'b1;
            user_output_n <= 1'b1;
            channel_irq <= 1'b0;
            channel_irq_oe_n <= 1'b1;
        end
        else
        begin
            rts_n <= ~rts_active;
            dtr_n <= ~modem_control_reg[MCR_DTR];
            user_output_n <= ~modem_control_reg[MCR_IRQ_DRIVE];
            channel_irq_oe_n <= ~modem_control_reg[MCR_IRQ_DRIVE];
            channel_irq <= irq_enable_reg[IER_MODEM] & ring_edge_reg;
        end
    end

    // dma ready outputs; the release conditions win over the request conditions
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_ready_n <= 1'b1;
            tx_ready_n <= 1'b1;
        end
        else
        begin
            if (rx_level == '0 || rx_error)
                rx_ready_n <= 1'b1;
            else if (rx_level >= rx_threshold || rx_timeout)
                rx_ready_n <= 1'b0;
            if (tx_free == '0)
                tx_ready_n <= 1'b1;
            else if (tx_free >= tx_threshold)
                tx_ready_n <= 1'b0;
        end
    end

    always_comb
    begin
        modem_status = '0;
        modem_status[MSR_RING_EDGE] = ring_edge_reg;
        modem_status[MSR_RING_LEVEL] = ~ring_n;
        pin_status = '0;
        pin_status[PST_RX_READY_N] = rx_ready_n;
        pin_status[PST_TX_READY_N] = tx_ready_n;
        pin_status[PST_IRQ] = channel_irq;
        pin_status[PST_RTS_N] = rts_n;
    end
endmodule

// [bench/uart_pin_assertions.sv]
// port-level assertions for the dual serial pin control block
`timescale 1ns/1ns
module uart_pin_assertions
#(
    parameter int LEVEL_W = 7
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [uart_pin_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic txd_a,
    input wire logic rts_a_n,
    input wire logic dtr_a_n,
    input wire logic user_output_a_n,
    input wire logic channel_irq_a,
    input wire logic channel_irq_a_oe_n,
    input wire logic rx_ready_a_n,
    input wire logic tx_ready_a_n,
    input wire logic [LEVEL_W-1:0] rx_level_a,
    input wire logic rx_error_a,
    input wire logic [LEVEL_W-1:0] tx_free_a
);
    import uart_pin_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic done;
    logic wr_mcr;
    assign done = psel && penable && pready;
    assign wr_mcr = done && pwrite && paddr == {3'h0, IDX_MODEM_CTRL, 2'h0};
    a_apb_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_unmapped: assert property (done && (paddr[1:0] != 2'h0 || paddr[7:6] != 2'h0) |-> pslverr)
        else $error("unmapped access without error");
    a_dtr_follow: assert property (wr_mcr |-> ##2 dtr_a_n == !$past(pwdata[MCR_DTR], 2))
        else $error("dtr pin does not follow control write");
    a_user_drive: assert property (wr_mcr |-> ##2 user_output_a_n == !$past(pwdata[MCR_IRQ_DRIVE], 2))
        else $error("user output does not follow control write");
    a_rts_clear: assert property (wr_mcr && !pwdata[MCR_RTS] |-> ##2 rts_a_n)
        else $error("rts pin low after clearing its bit");
    a_irq_float: assert property (channel_irq_a_oe_n == user_output_a_n)
        else $error("irq enable and user output disagree");
    a_rx_empty: assert property (rx_level_a == 0 || rx_error_a |=> rx_ready_a_n)
        else $error("rx ready low while empty or errored");
    a_tx_full: assert property (tx_free_a == 0 |=> tx_ready_a_n)
        else $error("tx ready low while full");
    a_loop_quiet: assert property (wr_mcr && pwdata[MCR_LOOPBACK] |-> ##2 txd_a [*3])
        else $error("transmit pin active in loopback");
    cover property ($rose(channel_irq_a));
    cover property (!rx_ready_a_n && !tx_ready_a_n);
    cover property (done && pslverr);
endmodule

bind dual_uart_pin_control uart_pin_assertions #(.LEVEL_W(LEVEL_W)) i_uart_pin_assertions (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .txd_a, .rts_a_n, .dtr_a_n, .user_output_a_n,
    .channel_irq_a, .channel_irq_a_oe_n, .rx_ready_a_n, .tx_ready_a_n, .rx_level_a, .rx_error_a, .tx_free_a);

// [bench/modem_model.sv]
// modem side of both channels: ring indicate and receive lines
`timescale 1ns/1ns
module modem_model
(
    input wire logic [1:0] ring_on,
    input wire logic [1:0] line_bit,
    output logic ring_a_n,
    output logic ring_b_n,
    output logic rxd_a,
    output logic rxd_b
);
    // ring pins are active low
    assign ring_a_n = !ring_on[0];
    assign ring_b_n = !ring_on[1];
    assign rxd_a = line_bit[0];
    assign rxd_b = line_bit[1];
endmodule

// [bench/tb.sv]
// self-checking bench for the dual serial pin control block
`timescale 1ns/1ns
module tb;
    import uart_pin_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [1:0] ring_on, line_bit;
    logic ring_a_n, ring_b_n, rxd_a, rxd_b, txd_a, txd_b, rts_a_n, rts_b_n, dtr_a_n, dtr_b_n;
    logic user_output_a_n, user_output_b_n, channel_irq_a, channel_irq_b, channel_irq_a_oe_n, channel_irq_b_oe_n;
    logic rx_ready_a_n, rx_ready_b_n, tx_ready_a_n, tx_ready_b_n, core_txd_a, core_txd_b, core_rxd_a, core_rxd_b;
    logic rx_timeout_a, rx_timeout_b, rx_error_a, rx_error_b, rx_halt_a, rx_halt_b;
    logic [6:0] rx_level_a, rx_level_b, tx_free_a, tx_free_b;
    int n_fail = 0;
    int compares = 0;
    logic [7:0] mv [4] = '{8'h0B, 8'h00, 8'h08, 8'h03};
    // rx level, tx free, then timeout, error, expected rx ready, expected tx ready
    logic [19:0] st [9] = '{20'h01400, 20'h01007, 20'h01010, 20'h00012, 20'h01003,
        20'h013B9, 20'h3B3C0, 20'h003C2, 20'h3C3B0};
    modem_model i_modem_model (.ring_on, .line_bit, .ring_a_n, .ring_b_n, .rxd_a, .rxd_b);
    dual_uart_pin_control i_dual_uart_pin_control (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .ring_a_n, .ring_b_n, .rxd_a, .rxd_b, .txd_a, .txd_b, .rts_a_n, .rts_b_n,
        .dtr_a_n, .dtr_b_n, .user_output_a_n, .user_output_b_n, .channel_irq_a, .channel_irq_b,
        .channel_irq_a_oe_n, .channel_irq_b_oe_n, .rx_ready_a_n, .rx_ready_b_n, .tx_ready_a_n, .tx_ready_b_n,
        .core_txd_a, .core_txd_b, .core_rxd_a, .core_rxd_b, .rx_level_a, .rx_level_b, .rx_timeout_a,
        .rx_timeout_b, .rx_error_a, .rx_error_b, .tx_free_a, .tx_free_b, .rx_halt_a, .rx_halt_b);
    initial
    begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end
    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
        compares++;
        if (g !== x)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", s, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'h1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        if (n == 20)
        begin
            n_fail++;
            $display("[ERR] pready expected 1 seen %b", pready);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rdc(input string s, input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
        apb(1'h0, a, 8'h00);
        chk(s, {24'h0, x}, r & {24'h0, m});
    endtask
    task automatic settle();
        repeat (3) @(posedge pclk);
    endtask
    task automatic summarize();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        repeat (4000) @(posedge pclk);
        n_fail++;
        summarize();
    end
    initial
    begin
        presetn = 1'h0;
        {psel, penable, pwrite, rx_timeout_a, rx_timeout_b, rx_error_a, rx_error_b, rx_halt_a, rx_halt_b} = '0;
        {paddr, pwdata, rx_level_a, rx_level_b, ring_on, line_bit, core_txd_a, core_txd_b} = '0;
        tx_free_a = 7'h40;
        tx_free_b = 7'h40;
        repeat (5) @(posedge pclk);
        chk("txd_a", 1'h1, txd_a);
        chk("core_rxd_a", 1'h1, core_rxd_a);
        chk("rts_a_n", 1'h1, rts_a_n);
        chk("dtr_a_n", 1'h1, dtr_a_n);
        chk("user_a", 1'h1, user_output_a_n);
        chk("irq_oe_a", 1'h1, channel_irq_a_oe_n);
        presetn <= 1'h1;
        for (int i = 0; i < 5; i++)
            rdc("reg reset", 8'(i * 4), 8'hFF, 8'h00);
        apb(1'h1, 8'h00, 8'hA5);
        rdc("scratch_a", 8'h00, 8'hFF, 8'hA5);
        rdc("scratch_b", 8'h20, 8'hFF, 8'h00);
        apb(1'h0, 8'h41, 8'h00);
        chk("pslverr", 1'h1, e);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'h1, 8'h10, mv[i]);
            settle();
            chk("rts_a_n", !mv[i][1], rts_a_n);
            chk("dtr_a_n", !mv[i][0], dtr_a_n);
            chk("user_a", !mv[i][3], user_output_a_n);
            chk("irq_oe_a", !mv[i][3], channel_irq_a_oe_n);
            chk("rts_b_n", 1'h1, rts_b_n);
        end
        apb(1'h1, 8'h30, 8'h08);
        settle();
        chk("user_b", 1'h0, user_output_b_n);
        chk("irq_oe_b", 1'h0, channel_irq_b_oe_n);
        rx_halt_a <= 1'h1;
        settle();
        chk("rts_a_n", 1'h0, rts_a_n);
        apb(1'h1, 8'h08, 8'h40);
        settle();
        chk("rts_a_n", 1'h1, rts_a_n);
        rx_halt_a <= 1'h0;
        core_txd_a <= 1'h1;
        settle();
        chk("rts_a_n", 1'h0, rts_a_n);
        chk("txd_a", 1'h1, txd_a);
        chk("core_rxd_a", 1'h0, core_rxd_a);
        core_txd_a <= 1'h0;
        apb(1'h1, 8'h10, 8'h10);
        line_bit <= 2'h3;
        settle();
        chk("txd_a", 1'h1, txd_a);
        chk("core_rxd_a", 1'h0, core_rxd_a);
        apb(1'h1, 8'h04, 8'h08);
        ring_on <= 2'h1;
        settle();
        rdc("ring level", 8'h18, 8'h40, 8'h40);
        chk("irq_a", 1'h0, channel_irq_a);
        ring_on <= 2'h0;
        settle();
        chk("irq_a", 1'h1, channel_irq_a);
        chk("irq_b", 1'h0, channel_irq_b);
        rdc("ring edge", 8'h18, 8'h44, 8'h04);
        settle();
        chk("irq_a", 1'h0, channel_irq_a);
        for (int i = 0; i < 9; i++)
        begin
            if (i == 4)
                apb(1'h1, 8'h0C, 8'hFF);
            rx_level_a <= st[i][18:12];
            tx_free_a <= st[i][10:4];
            rx_timeout_a <= st[i][3];
            rx_error_a <= st[i][2];
            settle();
            chk("rx_ready_a", st[i][1], rx_ready_a_n);
            chk("tx_ready_a", st[i][0], tx_ready_a_n);
        end
        // channel b pins and its pin status and level registers
        apb(1'h1, 8'h30, 8'h01);
        rx_level_b <= 7'h01;
        settle();
        chk("dtr_b_n", 1'h0, dtr_b_n);
        chk("irq_oe_b", 1'h1, channel_irq_b_oe_n);
        chk("txd_b", 1'h0, txd_b);
        chk("core_rxd_b", 1'h1, core_rxd_b);
        chk("rx_ready_b", 1'h0, rx_ready_b_n);
        chk("tx_ready_b", 1'h0, tx_ready_b_n);
        rdc("pin status b", 8'h34, 8'h0F, 8'h08);
        rdc("levels b", 8'h3C, 8'hFF, 8'h01);
        // reset in mid-run clears registers and pins
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        chk("dtr_b_n", 1'h1, dtr_b_n);
        chk("rx_ready_b", 1'h1, rx_ready_b_n);
        chk("tx_ready_b", 1'h1, tx_ready_b_n);
        presetn <= 1'h1;
        rdc("mcr_b", 8'h30, 8'hFF, 8'h00);
        rdc("trigger_a", 8'h0C, 8'hFF, 8'h00);
        summarize();
    end
endmodule
